// ==== rtl/omx_pkg.sv ====
/*
  Constants and types for the OR/move instruction execute block.
  Assumes a 14-bit instruction word, 8-bit data and 7-bit file index.
*/
// Contract
// RQ1: OR-into-register ORs accumulator with file register, writes chosen destination.
// RQ2: Copy-register opcode 00 1000 d fffffff reads file register, writes destination.
// RQ3: Copy-register with d clear goes to accumulator, d set back to source.
// RQ4: Copy-register updates zero flag from moved value; self-copy is a zero test.
// RQ5: Store-accumulator 00 0000 1 fffffff writes accumulator to register, flags unchanged.
// RQ6: One cycle each; literal loads accumulator, no flags; no-operation changes nothing.
package omx_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  // Field positions inside the instruction word
  localparam int OPC_MSB = 13;
  localparam int DEST_BIT = 7;
  localparam int LIT_MSB = 7;
  localparam int NOP_LO_MSB = 4;
  // Opcode fields
  localparam logic [5:0] OPC_OR_ACC = 6'h04;
  localparam logic [5:0] OPC_COPY = 6'h08;
  localparam logic [6:0] OPC_STORE = 7'h01;
  localparam logic [3:0] OPC_LITERAL = 4'hc;
  localparam logic [6:0] OPC_NOP_HI = 7'h00;
  localparam logic [4:0] OPC_NOP_LO = 5'h00;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;
  // Every instruction of the group retires after this many cycles
  localparam int EXEC_CYCLES = 1;

  typedef enum logic [5:0] {
    OMX_OP_NONE = 6'b00_0001,
    OMX_OP_OR_ACC = 6'b00_0010,
    OMX_OP_COPY = 6'b00_0100,
    OMX_OP_STORE = 6'b00_1000,
    OMX_OP_LITERAL = 6'b01_0000,
    OMX_OP_NOP = 6'b10_0000
  } omx_op_e;
endpackage

// ==== rtl/omx_decode.sv ====
/*
  Combinational opcode classifier for the OR/move instruction group.
  Assumes the instruction word is stable while it is presented.
*/
`timescale 1ns/1ps
module omx_decode (
  // Instruction
  input wire logic [13:0] instr,
  // Classification
  output omx_pkg::omx_op_e op,
  output logic dest_reg,
  output logic [6:0] reg_index,
  output logic [7:0] literal
);
  function automatic omx_pkg::omx_op_e classify(input logic [13:0] w);
    omx_pkg::omx_op_e k;
    k = omx_pkg::OMX_OP_NONE;
    if (w[omx_pkg::OPC_MSB -: 6] == omx_pkg::OPC_OR_ACC) begin
      k = omx_pkg::OMX_OP_OR_ACC; // [RQ1]
    end else if (w[omx_pkg::OPC_MSB -: 6] == omx_pkg::OPC_COPY) begin
      k = omx_pkg::OMX_OP_COPY; // [RQ2]
    end else if (w[omx_pkg::OPC_MSB -: 7] == omx_pkg::OPC_STORE) begin
      k = omx_pkg::OMX_OP_STORE; // [RQ5]
    end else if (w[omx_pkg::OPC_MSB -: 4] == omx_pkg::OPC_LITERAL) begin
      k = omx_pkg::OMX_OP_LITERAL; // [RQ6]
    end else if (w[omx_pkg::OPC_MSB -: 7] == omx_pkg::OPC_NOP_HI &&
                 w[omx_pkg::NOP_LO_MSB -: 5] == omx_pkg::OPC_NOP_LO) begin
      // Bits 6:5 are don't-care for the no-operation
      k = omx_pkg::OMX_OP_NOP; // [RQ6]
    end
    return k;
  endfunction

  always_comb begin
    op = classify(instr);
    dest_reg = instr[omx_pkg::DEST_BIT];
    reg_index = instr[omx_pkg::ADDR_W-1:0];
    literal = instr[omx_pkg::LIT_MSB:0];
  end
endmodule // omx_decode

// ==== rtl/omx_exec.sv ====
/*
  Execute stage for OR, copy, store, literal load and no-operation.
  Assumes fetch presents one instruction per valid cycle and the register
  file returns the word at instr[6:0] on freg_rdata in that same cycle.
*/
`timescale 1ns/1ps
module omx_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fetch side
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  // Register file read data for instr[6:0]
  input wire logic [7:0] freg_rdata,
  // Register file write port
  output logic freg_we,
  output logic [6:0] freg_waddr,
  output logic [7:0] freg_wdata,
  // Core state
  output logic [7:0] acc_value,
  output logic zero_flag,
  // Retirement
  output logic exec_done,
  output logic unsupported
);
  omx_pkg::omx_op_e op;
  logic dest_reg;
  logic [6:0] reg_index;
  logic [7:0] literal;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic zero_reg;
  logic zero_next;
  logic we_reg;
  logic we_next;
  logic [6:0] waddr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_next;
  logic done_reg;
  logic unsup_reg;
  logic [7:0] or_result;

  omx_decode u_decode (
    .instr(instr),
    .op(op),
    .dest_reg(dest_reg),
    .reg_index(reg_index),
    .literal(literal)
  );

  assign or_result = acc_reg | freg_rdata; // [RQ1]

  // Next-state of accumulator, flag and write port
  always_comb begin
    acc_next = acc_reg;
    zero_next = zero_reg;
    we_next = 1'b0;
    wdata_next = wdata_reg;
    if (instr_valid) begin
      case (op)
        omx_pkg::OMX_OP_OR_ACC: begin
          zero_next = (or_result == omx_pkg::DATA_ZERO); // [RQ1]
          if (dest_reg) begin
            we_next = 1'b1; // [RQ1]
            wdata_next = or_result;
          end else begin
            acc_next = or_result; // [RQ1]
          end
        end
        omx_pkg::OMX_OP_COPY: begin
          zero_next = (freg_rdata == omx_pkg::DATA_ZERO); // [RQ4]
          if (dest_reg) begin
            // Writing the same value back leaves the register as it was
            we_next = 1'b1; // [RQ3]
            wdata_next = freg_rdata; // [RQ4]
          end else begin
            acc_next = freg_rdata; // [RQ3]
          end
        end
        omx_pkg::OMX_OP_STORE: begin
          we_next = 1'b1; // [RQ5]
          wdata_next = acc_reg; // [RQ5]
        end
        omx_pkg::OMX_OP_LITERAL: begin
          acc_next = literal; // [RQ6]
        end
        omx_pkg::OMX_OP_NOP: begin
          acc_next = acc_reg; // [RQ6]
        end
        default: begin
          acc_next = acc_reg;
        end
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= omx_pkg::ACC_RST;
    end else begin
      acc_reg <= acc_next; // [RQ6]
    end
  end

  // Zero flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_reg <= omx_pkg::ZERO_RST;
    end else begin
      zero_reg <= zero_next; // [RQ4]
    end
  end

  // Register file write port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      we_reg <= 1'b0;
      waddr_reg <= omx_pkg::ADDR_RST;
      wdata_reg <= omx_pkg::DATA_ZERO;
    end else begin
      we_reg <= we_next;
      wdata_reg <= wdata_next;
      if (we_next) begin
        waddr_reg <= reg_index; // [RQ3]
      end
    end
  end

  // Retirement: one cycle for every instruction of the group
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
      unsup_reg <= 1'b0;
    end else begin
      done_reg <= instr_valid && (op != omx_pkg::OMX_OP_NONE); // [RQ6]
      unsup_reg <= instr_valid && (op == omx_pkg::OMX_OP_NONE);
    end
  end

  assign freg_we = we_reg;
  assign freg_waddr = waddr_reg;
  assign freg_wdata = wdata_reg;
  assign acc_value = acc_reg;
  assign zero_flag = zero_reg;
  assign exec_done = done_reg;
  assign unsupported = unsup_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence issue_s(omx_pkg::omx_op_e k, logic d);
    instr_valid && op == k && dest_reg == d;
  endsequence

  sequence writes_s(logic [7:0] v, logic [6:0] a);
    freg_we && freg_wdata == v && freg_waddr == a;
  endsequence

  or_to_acc_a: assert property ( // [RQ1]
    issue_s(omx_pkg::OMX_OP_OR_ACC, 1'b0) |=>
      acc_value == $past(or_result) && !freg_we &&
      zero_flag == ($past(or_result) == 8'h00))
    else $error("OR result not placed in accumulator");

  or_to_reg_a: assert property ( // [RQ1]
    issue_s(omx_pkg::OMX_OP_OR_ACC, 1'b1) |=>
      writes_s($past(or_result), $past(reg_index)) ##0
      (acc_value == $past(acc_value)))
    else $error("OR result not written to file register");

  copy_opcode_a: assert property ( // [RQ2]
    instr_valid && instr[13:8] == 6'h08 |-> op == omx_pkg::OMX_OP_COPY)
    else $error("copy opcode misdecoded");

  copy_to_acc_a: assert property ( // [RQ3]
    issue_s(omx_pkg::OMX_OP_COPY, 1'b0) |=>
      acc_value == $past(freg_rdata) && !freg_we)
    else $error("copy to accumulator wrong");

  copy_back_a: assert property ( // [RQ3]
    issue_s(omx_pkg::OMX_OP_COPY, 1'b1) |=>
      writes_s($past(freg_rdata), $past(instr[6:0])) ##0
      $stable(acc_value))
    else $error("copy back to source register wrong");

  copy_zero_a: assert property ( // [RQ4]
    instr_valid && op == omx_pkg::OMX_OP_COPY |=>
      zero_flag == ($past(freg_rdata) == 8'h00))
    else $error("zero flag not set from copied value");

  store_acc_a: assert property ( // [RQ5]
    issue_s(omx_pkg::OMX_OP_STORE, 1'b1) |=>
      writes_s($past(acc_value), $past(instr[6:0])) ##0
      ($stable(zero_flag) && $stable(acc_value)))
    else $error("store accumulator wrong or flag changed");

  literal_load_a: assert property ( // [RQ6]
    instr_valid && op == omx_pkg::OMX_OP_LITERAL |=>
      acc_value == $past(instr[7:0]) && $stable(zero_flag) && !freg_we)
    else $error("literal load wrong");

  nop_idle_a: assert property ( // [RQ6]
    instr_valid && op == omx_pkg::OMX_OP_NOP |=>
      $stable(acc_value) && $stable(zero_flag) && !freg_we && exec_done)
    else $error("no-operation changed state");

  single_cycle_a: assert property ( // [RQ6]
    instr_valid && op != omx_pkg::OMX_OP_NONE |=>
      exec_done && !unsupported)
    else $error("instruction did not retire in one cycle");

  // Words outside the group must leave every piece of state alone
  refused_word_a: assert property ( // [RQ6]
    instr_valid && op == omx_pkg::OMX_OP_NONE |=>
      unsupported && !exec_done && !freg_we &&
      $stable(acc_value) && $stable(zero_flag))
    else $error("word outside the group changed state");
endmodule // omx_exec

// ==== verif/omx_regfile_model.sv ====
/*
  Behavioural register file facing the execute block.
  Assumes reads are combinational and writes land on the rising edge.
*/
`timescale 1ns/1ps
module omx_regfile_model (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic [6:0] rd_index,
  output logic [7:0] rdata,
  // Write port
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'h00;
    end
  end
  // Same-cycle read; a write still in flight is forwarded to the reader
  assign rdata = (we && waddr == rd_index) ? wdata : mem[rd_index];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule // omx_regfile_model

// ==== verif/or_move_instr_exec_tb.sv ====
/*
  Self-checking bench for the OR/move execute block.
  Assumes omx_exec and the register file model; instructions are issued
  back to back at the falling edge and judged one cycle later.
*/
`timescale 1ns/1ps
module or_move_instr_exec_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] freg_rdata;
  logic freg_we;
  logic [6:0] freg_waddr;
  logic [7:0] freg_wdata;
  logic [7:0] acc_value;
  logic zero_flag;
  logic exec_done;
  logic unsupported;
  int fails = 0;
  int n_tests = 0;

  always #4 clk = ~clk;

  omx_exec dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr(instr), .freg_rdata(freg_rdata), .freg_we(freg_we),
    .freg_waddr(freg_waddr), .freg_wdata(freg_wdata),
    .acc_value(acc_value), .zero_flag(zero_flag), .exec_done(exec_done),
    .unsupported(unsupported));

  omx_regfile_model rf (.clk(clk), .rd_index(instr[6:0]),
    .rdata(freg_rdata), .we(freg_we), .waddr(freg_waddr),
    .wdata(freg_wdata));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Issue one word at a falling edge, judge it at the next one
  task automatic run(input logic [13:0] w, input logic [7:0] acc_e,
    input logic z_e, input logic we_e, input logic [7:0] wd_e,
    input logic un_e);
    instr_valid = 1'b1;
    instr = w;
    @(negedge clk);
    chk(acc_value, acc_e);
    chk({7'h00, zero_flag}, {7'h00, z_e});
    chk({6'h00, exec_done, unsupported}, {6'h00, !un_e, un_e});
    chk({7'h00, freg_we}, {7'h00, we_e});
    if (we_e) begin
      chk({1'b0, freg_waddr}, {1'b0, w[6:0]});
      chk(freg_wdata, wd_e);
    end
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_or();
    rf.mem[9] = 8'h13;
    run(14'h3091, 8'h91, 1'b0, 1'b0, 8'h00, 1'b0);
    run(14'h0489, 8'h91, 1'b0, 1'b1, 8'h93, 1'b0);
    run(14'h0409, 8'h93, 1'b0, 1'b0, 8'h00, 1'b0);
    run(14'h3000, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
    run(14'h0402, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
    idle();
    $display("t_or finished");
  endtask

  task automatic t_copy();
    rf.mem[6] = 8'h40;
    run(14'h30a5, 8'ha5, 1'b1, 1'b0, 8'h00, 1'b0);
    run(14'h0805, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
    run(14'h0886, 8'h00, 1'b0, 1'b1, 8'h40, 1'b0);
    run(14'h0806, 8'h40, 1'b0, 1'b0, 8'h00, 1'b0);
    idle();
    $display("t_copy finished");
  endtask

  task automatic t_store();
    run(14'h3300, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
    run(14'h0805, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
    run(14'h334f, 8'h4f, 1'b1, 1'b0, 8'h00, 1'b0);
    run(14'h0085, 8'h4f, 1'b1, 1'b1, 8'h4f, 1'b0);
    run(14'h0805, 8'h4f, 1'b0, 1'b0, 8'h00, 1'b0);
    idle();
    $display("t_store finished");
  endtask

  task automatic t_misc();
    run(14'h0060, 8'h4f, 1'b0, 1'b0, 8'h00, 1'b0);
    run(14'h3a35, 8'h4f, 1'b0, 1'b0, 8'h00, 1'b1);
    run(14'h0009, 8'h4f, 1'b0, 1'b0, 8'h00, 1'b1);
    idle();
    chk(rf.mem[6], 8'h40);
    $display("t_misc finished");
  endtask

  // Reset in mid-run clears state, then the block takes work again
  task automatic t_reset();
    sys_rst = 1'b1;
    @(negedge clk);
    chk(acc_value, 8'h00);
    chk({1'b0, freg_waddr}, 8'h00);
    chk(freg_wdata, 8'h00);
    sys_rst = 1'b0;
    @(negedge clk);
    run(14'h305a, 8'h5a, 1'b0, 1'b0, 8'h00, 1'b0);
    idle();
    $display("t_reset finished");
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk(acc_value, 8'h00);
    chk({6'h00, zero_flag, freg_we}, 8'h00);
    @(negedge clk);
    t_or();
    t_copy();
    t_store();
    t_misc();
    t_reset();
    report_and_stop();
  end

  // Guard against a hang
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule // or_move_instr_exec_tb
